/* File: design/lub_pkg.sv */
/*
  Constants, register map and state encodings of the LIN serial port.
  Assumes an 8-bit register port and a 40 MHz system clock.
*/
package lub_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_LINCTL = 4'h1;
  localparam logic [3:0] ADDR_BRH    = 4'h2;
  localparam logic [3:0] ADDR_BRL    = 4'h3;
  localparam logic [3:0] ADDR_STAT   = 4'h4;
  localparam logic [3:0] ADDR_TXD    = 4'h5;
  // ==========================================================
  // Field positions
  localparam int C_PORT_EN = 0;
  localparam int C_TX_EN   = 1;
  localparam int C_PAR_EN  = 2;
  localparam int C_PSEL    = 3;
  localparam int C_FLOW_EN = 4;
  localparam int C_MP_EN   = 5;
  localparam int C_MPBIT   = 6;
  localparam int C_WAKE    = 7;
  localparam int L_SLV     = 2;
  localparam int L_MST     = 3;
  localparam int L_AB_EN   = 4;
  localparam int S_WAKE    = 4;
  localparam int S_BRK     = 5;
  localparam int S_OVR     = 6;
  localparam int S_ABD     = 7;
  // ==========================================================
  // Reset values and counts
  localparam logic [15:0] BR_RST      = 16'h0100;
  localparam logic [3:0]  LEN_SAT     = 4'hF;
  localparam logic [3:0]  BRK_BITS    = 4'hB;
  localparam logic [3:0]  WAKE_BITS   = 4'h3;
  localparam logic [2:0]  AB_PRE_LAST = 3'h7;
  localparam logic [2:0]  AB_EDGE_4TH = 3'h4;
  localparam logic [3:0]  FRAME_BITS  = 4'hA;
  localparam logic [3:0]  FRAME_XBITS = 4'hB;
  // ==========================================================
  // Wake-up pulse timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int WAKE_MIN_NS   = 250000;
  localparam int WAKE_MAX_NS   = 5000000;
  localparam int WAKE_MIN_CYC  = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MAX_CYC  = WAKE_MAX_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Bus state field encodings
  typedef enum logic [1:0] {
    LS_SLEEP    = 2'b00,
    LS_WAIT_BRK = 2'b01,
    LS_AUTOBAUD = 2'b10,
    LS_ACTIVE   = 2'b11
  } lub_state_t;
endpackage

/* File: design/lub_low_if.sv */
/*
  Carrier between the port and its low-pulse timer.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface lub_low_if;
  logic [15:0] bit_div;
  logic        run;
  logic        rx_low;
  logic        ended;
  logic [3:0]  len;
  modport tmr (input bit_div, run, rx_low, output ended, len);
  modport ctl (output bit_div, run, rx_low, input ended, len);
endinterface

/* File: design/lub_low_timer.sv */
/*
  Times a low period on the receive line in bit periods, saturating at 15.
  Assumes rx_low is already synchronised to ref_clk.
*/
`timescale 1ns/1ps
module lub_low_timer (
  input wire logic ref_clk,
  input wire logic sys_rst,
  lub_low_if.tmr   lt
);
  import lub_pkg::*;

  logic [15:0] clk_cnt_r;
  logic [3:0]  len_r;
  logic        low_r;

  // ==========================================================
  // Bit-period counting while the line is low
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !lt.run) begin
      clk_cnt_r <= 16'h0000;
      len_r     <= 4'h0;
      low_r     <= 1'b0;
    end else if (lt.rx_low) begin
      low_r <= 1'b1;
      if ({1'b0, clk_cnt_r} + 17'h00001 >= {1'b0, lt.bit_div}) begin  // [R17]
        clk_cnt_r <= 16'h0000;
        if (len_r != LEN_SAT) len_r <= len_r + 4'h1;  // [R3]
      end else begin
        clk_cnt_r <= clk_cnt_r + 16'h0001;
      end
    end else begin
      low_r     <= 1'b0;
      clk_cnt_r <= 16'h0000;
      if (!low_r) len_r <= 4'h0;  // Length holds through the end cycle and the cycle after it
    end
  end

  // End of a low period
  assign lt.ended = low_r & ~lt.rx_low & lt.run;
  assign lt.len   = len_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_STOP_IDLE: assert property (!lt.run |=> len_r == 4'h0 && !lt.ended)  // [R4]
    else $error("low timer active while port stopped");
  AST_LEN_SAT: assert property (lt.run && lt.rx_low && len_r == LEN_SAT |=> len_r == LEN_SAT)  // [R3]
    else $error("length field left saturation");
endmodule // lub_low_timer

/* File: design/lub_uart.sv */
/*
  LIN serial port: wake-up timing, slave break detection, autobaud and transmitter.
  Assumes a plain register port on ref_clk; rxd and cts come from pins.
*/
// The register addresses and strobed register access were left to the implementer.
// Notes on behaviour
// [R1] A wake-up request holds the line low at least 250 us and under 5 ms; a zero character also serves.
// [R2] When enabled and not stopped, a low pulse of 3 or more bit times raises a wake event at its end; the code raises it only in bus state 00.
// [R3] The measured low length in bit times is readable and saturates at F above 15 bit times.
// [R4] While the processor is stopped the port times and reports nothing.
// [R5] After a wake-up, software moves the port into the master or slave wait-for-break state.
// [R6] Writing 00 to the bus state field puts the port to sleep, purely at software's choice.
// [R7] Slave operation holds with master bit 0, slave bit 1 and bus state 01, autobaud enable either way.
// [R8] In wait-for-break, a low of 11 or more bit times is a break and raises a break event.
// [R9] In wait-for-break, a low shorter than 11 bit times raises no break event.
// [R10] After a valid break the port enters autobaud and times the first 8 bits of the synch character.
// [R11] In autobaud the baud counter steps every 8th clock from the start bit to the start of bit 7.
// [R12] At the end of autobaud with autobaud enabled the count is copied into the baud reload registers.
// [R13] A baud counter overflow before bit 7 raises overrun, sets the overrun flag and keeps the reload.
// [R14] Software programs baud, pins, optional nine-bit mode, then transmit enable, in that order.
// [R15] Parity, even or odd, applies only while multiprocessor mode is off.
// [R16] The flow control bit decides whether CTS gates transmission; cleared, CTS is ignored.
// [R17] Low durations are counted in bit periods from the current baud setting while the line is low.
`timescale 1ns/1ps
module lub_uart #(
  parameter int WAKE_HOLD_CYC = lub_pkg::WAKE_MIN_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       rxd_pin,
  input  wire logic       cts_n_pin,
  input  wire logic       cpu_stop,
  output logic            txd_pin,
  output logic            wake_evt,
  output logic            break_evt,
  output logic            ab_overrun_evt,
  output logic            ab_done_evt
);
  import lub_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0]  ctrl_r;
  logic        master_role_bit_r, slave_role_bit_r, autobaud_enable_bit_r;
  lub_state_t  bus_state_field_r;
  logic [7:0]  brh_r, brl_r;
  logic [3:0]  rx_low_length_field_r;
  logic        wake_flag_r, brk_flag_r, ovr_flag_r, abd_flag_r;
  logic        rxd_m_r, rxd_s_r, rxd_d_r, cts_m_r, cts_s_r;
  logic        ab_run_r;
  logic [2:0]  ab_pre_r, ab_edges_r;
  logic [15:0] baud_generator_counter_r;
  logic [10:0] tx_shift_r;
  logic [3:0]  tx_bits_r;
  logic [15:0] tx_cnt_r;
  logic        tx_pend_r;
  logic [7:0]  tx_data_r;
  logic [17:0] wake_cnt_r;
  logic        txd_r;
  logic [7:0]  rdata_r;
  logic        port_run, slave_wb, fall, brk_hit, wake_hit, ab_fin, ab_ovf;
  logic        tx_busy, tx_go, wake_go, extra_en, extra_bit, bit_tick;
  logic        wr_ctrl, wr_lin, wr_stat, wr_txd;
  logic [15:0] bit_div;

  lub_low_if lt ();

  // ==========================================================
  // Pin synchronisers and edge detect
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
      rxd_d_r <= 1'b1;
      cts_m_r <= 1'b1;
      cts_s_r <= 1'b1;
    end else begin
      rxd_m_r <= rxd_pin;
      rxd_s_r <= rxd_m_r;
      rxd_d_r <= rxd_s_r;
      cts_m_r <= cts_n_pin;
      cts_s_r <= cts_m_r;
    end
  end

  // Decode and shared terms
  assign wr_ctrl  = reg_wr && reg_addr == ADDR_CTRL;
  assign wr_lin   = reg_wr && reg_addr == ADDR_LINCTL;
  assign wr_stat  = reg_wr && reg_addr == ADDR_STAT;
  assign wr_txd   = reg_wr && reg_addr == ADDR_TXD;
  assign bit_div  = {brh_r, brl_r};
  assign fall     = rxd_d_r & ~rxd_s_r;
  assign port_run = ctrl_r[C_PORT_EN] & ~cpu_stop;  // [R4]
  assign slave_wb = ~master_role_bit_r & slave_role_bit_r & (bus_state_field_r == LS_WAIT_BRK);  // [R7]

  // ==========================================================
  // Low-pulse timer
  assign lt.bit_div = bit_div;
  assign lt.run     = port_run;
  assign lt.rx_low  = ~rxd_s_r;

  lub_low_timer u_low (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .lt      (lt)
  );

  // Break and wake classification at the end of a low
  assign brk_hit  = lt.ended && slave_wb && lt.len >= BRK_BITS;  // [R8] [R9]
  assign wake_hit = lt.ended && bus_state_field_r == LS_SLEEP && lt.len >= WAKE_BITS;  // [R2]

  // ==========================================================
  // Autobaud measurement of the synch character
  assign ab_fin = ab_run_r && bus_state_field_r == LS_AUTOBAUD && fall && ab_edges_r == AB_EDGE_4TH;
  assign ab_ovf = ab_run_r && bus_state_field_r == LS_AUTOBAUD && !ab_fin
                  && ab_pre_r == AB_PRE_LAST && baud_generator_counter_r == 16'hFFFF;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || bus_state_field_r != LS_AUTOBAUD || !port_run) begin
      ab_run_r                 <= 1'b0;
      ab_pre_r                 <= 3'h0;
      ab_edges_r               <= 3'h0;
      baud_generator_counter_r <= 16'h0000;
    end else if (!ab_run_r) begin
      if (fall) begin  // Start bit opens the window
        ab_run_r   <= 1'b1;
        ab_pre_r   <= 3'h1;  // Start edge is the first counted clock
        ab_edges_r <= 3'h1;
      end
    end else if (ab_fin || ab_ovf) begin
      ab_run_r <= 1'b0;
    end else begin
      ab_pre_r <= ab_pre_r + 3'h1;
      if (ab_pre_r == AB_PRE_LAST)
        baud_generator_counter_r <= baud_generator_counter_r + 16'h0001;  // [R11]
      if (fall) ab_edges_r <= ab_edges_r + 3'h1;
    end
  end

  // ==========================================================
  // Control and LIN registers, bus state sequencing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r                <= 8'h00;
      master_role_bit_r     <= 1'b0;
      slave_role_bit_r      <= 1'b0;
      autobaud_enable_bit_r <= 1'b0;
      bus_state_field_r     <= LS_SLEEP;
    end else begin
      if (wr_ctrl) ctrl_r <= {1'b0, reg_wdata[6:0]};  // Wake request bit does not stay
      if (wr_lin) begin
        master_role_bit_r     <= reg_wdata[L_MST];
        slave_role_bit_r      <= reg_wdata[L_SLV];
        autobaud_enable_bit_r <= reg_wdata[L_AB_EN];
        bus_state_field_r     <= lub_state_t'(reg_wdata[1:0]);  // [R6] [R5]
      end else if (brk_hit) begin
        bus_state_field_r <= LS_AUTOBAUD;  // [R10]
      end else if (ab_fin) begin
        bus_state_field_r <= LS_ACTIVE;
      end else if (ab_ovf) begin
        bus_state_field_r <= LS_WAIT_BRK;
      end
    end
  end

  // Baud reload, software or autobaud
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      brh_r <= BR_RST[15:8];
      brl_r <= BR_RST[7:0];
    end else if (reg_wr && reg_addr == ADDR_BRH) begin
      brh_r <= reg_wdata;
    end else if (reg_wr && reg_addr == ADDR_BRL) begin
      brl_r <= reg_wdata;
    end else if (ab_fin && autobaud_enable_bit_r) begin
      {brh_r, brl_r} <= baud_generator_counter_r;  // [R12]
    end
  end

  // ==========================================================
  // Status flags, write one to clear, set wins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_flag_r           <= 1'b0;
      brk_flag_r            <= 1'b0;
      ovr_flag_r            <= 1'b0;
      abd_flag_r            <= 1'b0;
      rx_low_length_field_r <= 4'h0;
    end else begin
      wake_flag_r <= wake_hit | (wake_flag_r & ~(wr_stat & reg_wdata[S_WAKE]));
      brk_flag_r  <= brk_hit | (brk_flag_r & ~(wr_stat & reg_wdata[S_BRK]));
      ovr_flag_r  <= ab_ovf | (ovr_flag_r & ~(wr_stat & reg_wdata[S_OVR]));  // [R13]
      abd_flag_r  <= ab_fin | (abd_flag_r & ~(wr_stat & reg_wdata[S_ABD]));
      if (lt.ended) rx_low_length_field_r <= lt.len;  // [R3]
    end
  end

  // One-cycle event pulses
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_evt       <= 1'b0;
      break_evt      <= 1'b0;
      ab_overrun_evt <= 1'b0;
      ab_done_evt    <= 1'b0;
    end else begin
      wake_evt       <= wake_hit;
      break_evt      <= brk_hit;
      ab_overrun_evt <= ab_ovf;
      ab_done_evt    <= ab_fin;
    end
  end

  // ==========================================================
  // Transmitter
  assign tx_busy   = tx_bits_r != 4'h0 || wake_cnt_r != 18'h00000;
  assign tx_go     = tx_pend_r && !tx_busy && (!ctrl_r[C_FLOW_EN] || !cts_s_r);  // [R16]
  assign wake_go   = wr_ctrl && reg_wdata[C_WAKE] && ctrl_r[C_TX_EN] && !tx_busy && !tx_pend_r;
  assign extra_en  = ctrl_r[C_MP_EN] | ctrl_r[C_PAR_EN];
  assign extra_bit = ctrl_r[C_MP_EN] ? ctrl_r[C_MPBIT] : (ctrl_r[C_PSEL] ^ (^tx_data_r));  // [R15]
  assign bit_tick  = {1'b0, tx_cnt_r} + 17'h00001 >= {1'b0, bit_div};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_pend_r  <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_shift_r <= 11'h7FF;
      tx_bits_r  <= 4'h0;
      tx_cnt_r   <= 16'h0000;
    end else begin
      if (wr_txd && ctrl_r[C_TX_EN] && !tx_busy && !tx_pend_r) begin
        tx_pend_r <= 1'b1;
        tx_data_r <= reg_wdata;  // A zero byte doubles as a wake-up pulse [R1]
      end else if (tx_go) begin
        tx_pend_r <= 1'b0;
      end
      if (tx_go) begin
        tx_shift_r <= {1'b1, extra_en ? extra_bit : 1'b1, tx_data_r, 1'b0};
        tx_bits_r  <= extra_en ? FRAME_XBITS : FRAME_BITS;
        tx_cnt_r   <= 16'h0000;
      end else if (tx_bits_r != 4'h0) begin
        if (bit_tick) begin
          tx_cnt_r   <= 16'h0000;
          tx_shift_r <= {1'b1, tx_shift_r[10:1]};
          tx_bits_r  <= tx_bits_r - 4'h1;
        end else begin
          tx_cnt_r <= tx_cnt_r + 16'h0001;
        end
      end
    end
  end

  // Wake-up pulse hold and line driver
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_cnt_r <= 18'h00000;
      txd_r      <= 1'b1;
    end else begin
      if (wake_go) wake_cnt_r <= 18'(WAKE_HOLD_CYC);  // [R1]
      else if (wake_cnt_r != 18'h00000) wake_cnt_r <= wake_cnt_r - 18'h00001;
      txd_r <= (wake_cnt_r != 18'h00000) ? 1'b0 : (tx_bits_r != 4'h0 ? tx_shift_r[0] : 1'b1);
    end
  end
  assign txd_pin = txd_r;

  // ==========================================================
  // Register read port
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL:   rdata_r <= ctrl_r;
        ADDR_LINCTL: rdata_r <= {3'h0, autobaud_enable_bit_r, master_role_bit_r, slave_role_bit_r,
                                 bus_state_field_r};
        ADDR_BRH:    rdata_r <= brh_r;
        ADDR_BRL:    rdata_r <= brl_r;
        ADDR_STAT:   rdata_r <= {abd_flag_r, ovr_flag_r, brk_flag_r, wake_flag_r, rx_low_length_field_r};
        ADDR_TXD:    rdata_r <= {6'h00, tx_pend_r, tx_busy};
        default:     rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ab_tick;
    ab_run_r && bus_state_field_r == LS_AUTOBAUD && !ab_fin && !ab_ovf && ab_pre_r == AB_PRE_LAST;
  endsequence
  sequence s_ab_idle_tick;
    ab_run_r && bus_state_field_r == LS_AUTOBAUD && !ab_fin && !ab_ovf && ab_pre_r != AB_PRE_LAST;
  endsequence

  AST_WAKE_HOLD: assert property (wake_go |=> ##1 !txd_pin [*8])  // [R1]
    else $error("wake pulse not driven low");
  AST_WAKE_EVT: assert property (lt.ended && bus_state_field_r == LS_SLEEP && lt.len >= WAKE_BITS
                                 |=> wake_evt && wake_flag_r)  // [R2]
    else $error("wake event missing");
  AST_LEN_FIELD: assert property (lt.ended |=> rx_low_length_field_r == $past(lt.len))  // [R3]
    else $error("low length not captured");
  AST_SLEEP_WR: assert property (wr_lin && reg_wdata[1:0] == 2'b00 |=> bus_state_field_r == LS_SLEEP)  // [R6]
    else $error("sleep state not entered");
  AST_BRK_EVT: assert property (lt.ended && slave_wb && lt.len >= BRK_BITS |=> break_evt && brk_flag_r)  // [R8]
    else $error("break not reported");
  AST_NO_SHORT_BRK: assert property (lt.ended && lt.len < BRK_BITS |=> !break_evt)  // [R9]
    else $error("short low reported as break");
  AST_TO_AUTOBAUD: assert property (break_evt && !$past(wr_lin) |-> bus_state_field_r == LS_AUTOBAUD)  // [R10]
    else $error("autobaud not entered after break");
  AST_AB_STEP: assert property (s_ab_tick
                                |=> baud_generator_counter_r == $past(baud_generator_counter_r) + 16'h0001)  // [R11]
    else $error("baud counter missed a step");
  AST_AB_HOLD: assert property (s_ab_idle_tick |=> $stable(baud_generator_counter_r))  // [R11]
    else $error("baud counter stepped off the eighth clock");
  AST_AB_LOAD: assert property (ab_fin && autobaud_enable_bit_r && !reg_wr
                                |=> bit_div == $past(baud_generator_counter_r))  // [R12]
    else $error("reload not updated by autobaud");
  AST_AB_OVR: assert property (ab_ovf && !reg_wr |=> ovr_flag_r && ab_overrun_evt && $stable(bit_div))  // [R13]
    else $error("overrun handling wrong");
  AST_PARITY: assert property (tx_go && ctrl_r[C_PAR_EN] && !ctrl_r[C_MP_EN]
                               |=> tx_shift_r[9] == ($past(ctrl_r[C_PSEL]) ^ (^$past(tx_data_r))))  // [R15]
    else $error("parity bit wrong");
  AST_CTS_GATE: assert property (tx_pend_r && !tx_busy && ctrl_r[C_FLOW_EN] && cts_s_r |=> tx_bits_r == 4'h0)  // [R16]
    else $error("sent while CTS deasserted");
  AST_CTS_OFF: assert property (tx_pend_r && !tx_busy && !ctrl_r[C_FLOW_EN] |=> tx_bits_r != 4'h0)  // [R16]
    else $error("CTS not ignored");
endmodule // lub_uart

/* File: verif/lub_lin_node.sv */
/*
  Behavioural LIN node facing the serial port: sends pulses and bytes, samples frames.
  Assumes it shares ref_clk with the port; the wired-AND bus idles high.
*/
`timescale 1ns/1ps
module lub_lin_node (
  input  wire logic ref_clk,
  input  wire logic bus_in,
  output logic      node_tx
);
  // ==========================================================
  // Recessive at rest
  initial node_tx = 1'b1;

  // Dominant pulse of whole bits plus half a bit
  task automatic send_low(input int bits, input int div);
    @(posedge ref_clk) node_tx <= 1'b0;
    repeat (bits * div + div / 2) @(posedge ref_clk);
    node_tx <= 1'b1;
  endtask

  // One-bit delimiter, then start, data LSB first, stop
  task automatic send_byte(input logic [7:0] data, input int div);
    logic [9:0] frm;
    frm = {1'b1, data, 1'b0};
    repeat (div) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      node_tx <= frm[i];
      repeat (div) @(posedge ref_clk);
    end
  endtask

  // Sample a frame at mid bit; unsampled bits read 1
  task automatic rx_frame(input int nbits, input int div, output logic [11:0] frm);
    int n;
    n = 0;
    frm = 12'hFFF;
    while (bus_in !== 1'b0 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (div / 2) @(posedge ref_clk);
    for (int i = 0; i < nbits; i++) begin
      frm[i] = bus_in;
      repeat (div) @(posedge ref_clk);
    end
  endtask
endmodule // lub_lin_node

/* File: verif/lin_uart_break_autobaud_bench.sv */
/*
  Self-checking bench for the LIN serial port.
  Assumes the design package and the LIN node model are compiled first.
*/
`timescale 1ns/1ps
module lin_uart_break_autobaud_bench;
  import lub_pkg::*;
  localparam int WAKE_HOLD = 20;
  logic ref_clk, sys_rst, reg_wr, reg_rd, cts_n_pin, cpu_stop;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic txd_pin, node_tx, wake_evt, break_evt, ab_overrun_evt, ab_done_evt;
  wire rxd_pin = node_tx & txd_pin;
  int err_count, cmp_count, div, wake_cnt, brk_cnt, abd_cnt, ovr_cnt, w0;
  logic [11:0] f;

  lub_uart #(.WAKE_HOLD_CYC(WAKE_HOLD)) lub_uart_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin),
    .cts_n_pin(cts_n_pin), .cpu_stop(cpu_stop), .txd_pin(txd_pin), .wake_evt(wake_evt),
    .break_evt(break_evt), .ab_overrun_evt(ab_overrun_evt), .ab_done_evt(ab_done_evt)
  );
  lub_lin_node lub_lin_node_inst (.ref_clk(ref_clk), .bus_in(rxd_pin), .node_tx(node_tx));

  // ==========================================================
  // Clock and event counters
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (wake_evt === 1'b1) wake_cnt++;
    if (break_evt === 1'b1) brk_cnt++;
    if (ab_done_evt === 1'b1) abd_cnt++;
    if (ab_overrun_evt === 1'b1) ovr_cnt++;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;  // Data stood through the cycle after the strobe
  endtask
  task automatic pulse(input int bits);
    lub_lin_node_inst.send_low(bits, div);
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic txf(input logic [7:0] c, input logic [7:0] d, input int nb, input logic [11:0] e);
    wr(ADDR_CTRL, c);
    wr(ADDR_TXD, d);
    lub_lin_node_inst.rx_frame(nb, div, f);
    check("tx frame", {4'h0, f}, {4'h0, e});
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [3:0] a [7];
    logic [7:0] e [7];
    a = '{ADDR_CTRL, ADDR_LINCTL, ADDR_BRH, ADDR_BRL, ADDR_STAT, ADDR_TXD, 4'hF};
    e = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    wr(4'hF, 8'h5A);
    for (int i = 0; i < 7; i++) begin
      rd(a[i], v);
      check("reset value", {8'h00, v}, {8'h00, e[i]});
    end
  endtask
  task automatic t_wake();
    wr(ADDR_BRH, 8'h00);
    wr(ADDR_BRL, 8'h10);
    pulse(5);
    check("disabled wake", 16'(wake_cnt), 16'h0000);
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_TXD, 8'h00);
    rd(ADDR_TXD, v);
    check("tx refused", {8'h00, v}, 16'h0000);
    wr(ADDR_LINCTL, 8'h00);
    w0 = wake_cnt;
    pulse(2);
    check("short wake", 16'(wake_cnt), 16'(w0));
    pulse(5);
    check("wake", 16'(wake_cnt), 16'(w0 + 1));
    rd(ADDR_STAT, v);
    check("wake length", {8'h00, v}, 16'h0015);
    wr(ADDR_STAT, 8'hFF);
    pulse(20);
    rd(ADDR_STAT, v);
    check("saturated length", {8'h00, v}, 16'h001F);
    cpu_stop <= 1'b1;
    pulse(5);
    check("stopped wake", 16'(wake_cnt), 16'(w0 + 2));
    cpu_stop <= 1'b0;
  endtask
  task automatic t_break();
    w0 = brk_cnt;
    wr(ADDR_LINCTL, 8'h1D);
    pulse(12);
    check("master break", 16'(brk_cnt), 16'(w0));
    wr(ADDR_LINCTL, 8'h15);
    pulse(10);
    check("short break", 16'(brk_cnt), 16'(w0));
    pulse(12);
    check("break", 16'(brk_cnt), 16'(w0 + 1));
    rd(ADDR_LINCTL, v);
    check("autobaud state", {8'h00, v}, 16'h0016);
    w0 = abd_cnt;
    lub_lin_node_inst.send_byte(8'h55, 24);
    repeat (10) @(posedge ref_clk);
    check("autobaud done", 16'(abd_cnt), 16'(w0 + 1));
    rd(ADDR_BRH, v);
    check("reload high", {8'h00, v}, 16'h0000);
    rd(ADDR_BRL, v);
    check("reload low", {8'h00, v}, 16'h0018);
    rd(ADDR_STAT, v);
    check("autobaud flags", {14'h0000, v[S_ABD], v[S_OVR]}, 16'h0002);
    check("no overrun", 16'(ovr_cnt), 16'h0000);
    rd(ADDR_LINCTL, v);
    check("active state", {8'h00, v}, 16'h0017);
    div = 24;
  endtask
  task automatic t_tx();
    txf(8'h07, 8'hA5, 11, {3'b110, 8'hA5, 1'b0});
    txf(8'h0F, 8'hA5, 11, {3'b111, 8'hA5, 1'b0});
    txf(8'h67, 8'hA5, 11, {3'b111, 8'hA5, 1'b0});
    wr(ADDR_CTRL, 8'h13);
    wr(ADDR_TXD, 8'h5A);
    repeat (100) @(posedge ref_clk);
    check("held by cts", {15'h0, txd_pin}, 16'h0001);
    rd(ADDR_TXD, v);
    check("pending", {15'h0, v[1]}, 16'h0001);
    cts_n_pin <= 1'b0;
    lub_lin_node_inst.rx_frame(10, div, f);
    check("cts frame", {4'h0, f}, {7'h07, 8'h5A, 1'b0});
    cts_n_pin <= 1'b1;
    txf(8'h03, 8'h3C, 10, {3'b111, 8'h3C, 1'b0});
  endtask
  task automatic t_wake_tx();
    int k;
    int n;
    wr(ADDR_CTRL, 8'h83);
    k = 0;
    n = 0;
    while (txd_pin !== 1'b0 && k < 50) begin
      @(posedge ref_clk);
      k++;
    end
    while (txd_pin === 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    check("wake hold", 16'(n), 16'(WAKE_HOLD));
  endtask
  task automatic t_sleep();
    wr(ADDR_LINCTL, 8'h00);
    rd(ADDR_LINCTL, v);
    check("sleep state", {8'h00, v}, 16'h0000);
    w0 = wake_cnt;
    pulse(5);
    check("wake in sleep", 16'(wake_cnt), 16'(w0 + 1));
    rd(ADDR_STAT, v);
    check("length at new baud", {12'h000, v[3:0]}, 16'h0005);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    sys_rst   = 1'b1;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    cts_n_pin = 1'b1;
    cpu_stop  = 1'b0;
    div       = 16;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_wake();
    t_break();
    t_tx();
    t_wake_tx();
    t_sleep();
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end
endmodule // lin_uart_break_autobaud_bench
